// *** test/scsf_status_flags_sva.sv ***
// Port-level assertions for the channel-status and status-flag block
`timescale 1ns/100ps
module scsf_status_flags_sva (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Stream and pins
  input wire logic        sf_valid,
  input wire logic        sf_first,
  input wire logic        lock_pin,
  input wire logic        signal_present_pin,
  input wire logic        control_mode_pin_out,
  input wire logic        control_mode_pin_oe_n,
  // Host port and outputs
  input wire logic        reg_rd,
  input wire logic [6:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        status_update_flag,
  input wire logic [23:0] trunc_word,
  input wire logic [23:0] retx_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Host port
  // readback undisturbed
  property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  property p_upd_fall;
    $fell(status_update_flag) |-> $past(reg_rd) && ($past(reg_addr) inside {7'h2e, 7'h2f, 7'h30});
  endproperty
  a_upd_fall: assert property (p_upd_fall)
    else $error("update flag cleared unread");
  property p_upd_rise;
    $rose(status_update_flag) |-> $past(sf_valid && sf_first, 2);
  endproperty
  a_upd_rise: assert property (p_upd_rise)
    else $error("update flag rose off block end");

  // ==========================================================================
  // Audio words
  // truncation keeps top bits
  property p_trunc;
    sf_valid |=> ((trunc_word & ~retx_word) == 24'h0) && (trunc_word[23:8] == retx_word[23:8]);
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("truncated word mismatch");
  // words only move on a sub-frame
  property p_word_hold;
    !sf_valid |=> $stable(trunc_word) && $stable(retx_word);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("word moved without sub-frame");

  // ==========================================================================
  // Lock-loss flag on the mode pin
  // unlock shown
  property p_unlock;
    (!(lock_pin && signal_present_pin)) [*6] |-> control_mode_pin_out;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("mode pin low while unlocked");
  property p_lock; (lock_pin && signal_present_pin) [*6] |-> !control_mode_pin_out; endproperty
  a_lock: assert property (p_lock)
    else $error("mode pin high while locked");
  property p_oe_keep; !control_mode_pin_oe_n |=> !control_mode_pin_oe_n; endproperty
  a_oe_keep: assert property (p_oe_keep)
    else $error("mode pin drive released");
endmodule

bind scsf_status_flags scsf_status_flags_sva scsf_status_flags_sva_inst (.*);

// *** test/scsf_status_flags_tb.sv ***
// Bench for the channel-status and status-flag block
`timescale 1ns/100ps
module scsf_status_flags_tb;
  typedef struct packed {
    logic [39:0] cs;
    logic [7:0]  e2e, e2f, e30, e31;
    logic [23:0] mask;
  } scsf_row_t;
  logic        sys_clk = 1'b0, reset_n = 1'b0, lock_pin = 1'b1, signal_present_pin = 1'b1;
  logic        control_mode_pin_in = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
  logic        sf_valid, sf_first, c_bit, v_bit, parity_err, biphase_err, block_start;
  logic        control_mode_pin_out, control_mode_pin_oe_n, general_output_pin;
  logic        non_audio, status_update_flag;
  logic [23:0] audio_word, trunc_word, retx_word;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, rd;
  int          n_errors = 0, cmp_count = 0;
  // Block contents beside expected readback and mask
  scsf_row_t rows [7] = '{
    '{40'h3001050000, 8'h05, 8'h01, 8'h30, 8'h00, 24'hfffff0},
    '{40'h03d21a0000, 8'h1a, 8'h12, 8'h03, 8'h00, 24'hfffff0},
    '{40'hf4202f0000, 8'h2f, 8'h20, 8'hf4, 8'h00, 24'hffffc0},
    '{40'h9931340000, 8'h34, 8'h31, 8'h99, 8'h00, 24'hfffffe},
    '{40'h0a0e800000, 8'h80, 8'h0e, 8'h0a, 8'h00, 24'hfffff0},
    '{40'h6d05000002, 8'h00, 8'h05, 8'h6d, 8'h0a, 24'hfffff8},
    '{40'h0101000000, 8'h00, 8'h01, 8'h01, 8'h00, 24'hffffff}};
  // Steps: {first, invalid, parity, biphase, expected events}
  logic [11:0] steps [14] = '{12'hc01, 12'h000, 12'ha02, 12'h002, 12'h800, 12'h102, 12'h800,
    12'h000, 12'h800, 12'h802, 12'h002, 12'h800, 12'h000, 12'h002};

  always #5 sys_clk = ~sys_clk;

  scsf_status_flags scsf_status_flags_inst (.sys_clk, .reset_n, .sf_valid, .sf_first, .c_bit,
    .v_bit, .parity_err, .biphase_err, .block_start, .audio_word, .lock_pin, .signal_present_pin,
    .control_mode_pin_in, .control_mode_pin_out, .control_mode_pin_oe_n, .general_output_pin,
    .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .non_audio, .status_update_flag,
    .trunc_word, .retx_word);
  scsf_tx_model scsf_tx_model_inst (.sys_clk, .sf_valid, .sf_first, .c_bit, .v_bit, .parity_err,
    .biphase_err, .block_start, .audio_word);

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic pins(input logic lk, input logic sp, input logic exp);
    @(posedge sys_clk);
    {lock_pin, signal_present_pin} <= {lk, sp};
    repeat (8) @(posedge sys_clk);
    #1 check("mode_pin", control_mode_pin_out, exp);
    check("gpo_unlock", general_output_pin, exp);
  endtask
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #250000;
    n_errors++;
    final_report();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    #15 check("rdata_rst", reg_rdata, 8'h00);
    check("upd_rst", status_update_flag, 1'b0);
    check("gpo_rst", general_output_pin, 1'b1);
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 check("oe_hw", control_mode_pin_oe_n, 1'b0);
    check("locked", control_mode_pin_out, 1'b0);
    reg_write(scsf_pkg::ADDR_SOURCE_CHANNEL, 8'hff);
    reg_read(scsf_pkg::ADDR_SOURCE_CHANNEL, rd);
    check("ro_write", rd, scsf_pkg::RESET_CSTAT);
    reg_read(7'h7f, rd);
    check("unmapped", rd, 8'h00);
    for (int i = 0; i < 7; i++) begin
      scsf_tx_model_inst.send_block(rows[i].cs, 24'hffffff);
      repeat (6) @(posedge sys_clk);
      #1 check("upd_set", status_update_flag, 1'b1);
      reg_read(scsf_pkg::ADDR_SOURCE_CHANNEL, rd);
      check("src_chan", rd, rows[i].e2e);
      reg_read(scsf_pkg::ADDR_SAMPLING_CODE_A_ACCURACY, rd);
      check("sampling_code_a_acc", rd, rows[i].e2f);
      reg_read(scsf_pkg::ADDR_WORDLEN_ORIGFREQ, rd);
      check("wordlen", rd, rows[i].e30);
      check("upd_clr", status_update_flag, 1'b0);
      reg_read(scsf_pkg::ADDR_RX_STATUS, rd);
      check("rx_stat", rd, rows[i].e31);
      check("non_audio", non_audio, rows[i].e31[3]);
      scsf_tx_model_inst.send_sf(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'hffffff);
      #1 check("trunc", trunc_word, rows[i].mask);
      check("retx", retx_word, 24'hffffff);
      scsf_tx_model_inst.send_sf(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'hffffff);
    end
    reg_write(scsf_pkg::ADDR_WORDLEN_ORIGFREQ, 8'hfe);
    reg_read(scsf_pkg::ADDR_WORDLEN_ORIGFREQ, rd);
    check("ro_write2", rd, 8'h01);
    reg_write(scsf_pkg::ADDR_GPO_SELECT, {4'h0, scsf_pkg::GPO_INVALID});
    for (int k = 0; k < 14; k++) begin
      scsf_tx_model_inst.send_sf(steps[k][11], 1'b0, steps[k][10], steps[k][9], steps[k][8],
                                 1'b0, 24'h123456);
      reg_read(scsf_pkg::ADDR_EVENT_FLAGS, rd);
      check("events", rd, steps[k][7:0]);
      check("gpo_inv", general_output_pin, steps[k][0]);
    end
    reg_write(scsf_pkg::ADDR_GPO_SELECT, 8'h00);
    scsf_tx_model_inst.send_sf(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'hf87200);
    scsf_tx_model_inst.send_sf(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 24'h4e1f00);
    reg_read(scsf_pkg::ADDR_RX_STATUS, rd);
    check("sync_code", rd, 8'h0c);
    check("non_audio_s", non_audio, 1'b1);
    pins(1'b0, 1'b1, 1'b1);
    reg_read(scsf_pkg::ADDR_RX_STATUS, rd);
    check("unlock_stat", rd, 8'h01);
    pins(1'b1, 1'b0, 1'b1);
    pins(1'b1, 1'b1, 1'b0);
    reg_read(scsf_pkg::ADDR_RX_STATUS, rd);
    check("relock_stat", rd, 8'h00);
    final_report();
  end
endmodule

// *** test/scsf_tx_model.sv ***
// Transmitter model delivering recovered sub-frames
`timescale 1ns/100ps
module scsf_tx_model (
  // Clock
  input wire logic    sys_clk,
  // Sub-frame stream
  output logic        sf_valid,
  output logic        sf_first,
  output logic        c_bit,
  output logic        v_bit,
  output logic        parity_err,
  output logic        biphase_err,
  output logic        block_start,
  output logic [23:0] audio_word
);
  initial begin
    {sf_valid, sf_first, c_bit, v_bit, parity_err, biphase_err, block_start, audio_word} = '0;
  end

  // ==========================================================================
  // One sub-frame; fields inverted between strobes
  task automatic send_sf(input logic f, input logic c, input logic v, input logic pe,
                         input logic be, input logic bs, input logic [23:0] w);
    @(posedge sys_clk);
    sf_valid <= 1'b1;
    {sf_first, c_bit, v_bit, parity_err, biphase_err, block_start, audio_word} <= {f, c, v, pe, be, bs, w};
    @(posedge sys_clk);
    sf_valid <= 1'b0;
    {sf_first, c_bit, v_bit, parity_err, biphase_err, block_start, audio_word} <= ~{f, c, v, pe, be, bs, w};
  endtask

  // ==========================================================================
  // Whole 192-frame block; second channel carries the inverse status bit
  task automatic send_block(input logic [39:0] cs, input logic [23:0] w);
    logic cb;
    for (int fr = 0; fr < 192; fr++) begin
      cb = (fr < 40) ? cs[fr] : 1'b0;
      send_sf(1'b1, cb, 1'b0, 1'b0, 1'b0, fr == 0, w);
      send_sf(1'b0, ~cb, 1'b0, 1'b0, 1'b0, 1'b0, w);
    end
  endtask
endmodule

// *** verilog/scsf_cs_capture.sv ***
// Collects one block of channel-status bits from the first channel
`timescale 1ns/100ps
module scsf_cs_capture (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Stream in, block out
  scsf_cs_if.cap   cs
);

  // ==========================================================================
  // Frame position inside the block
  logic [7:0]  frame_idx_ff;
  logic        aligned_ff;
  logic [39:0] shift_ff;
  logic [39:0] nxt_shift;

  // Count frames on first-channel sub-frames only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_idx_ff <= 8'h00;
      aligned_ff   <= 1'b0;
    end else if (cs.sf_valid && cs.sf_first) begin
      if (cs.block_start) begin
        frame_idx_ff <= 8'h01;
        aligned_ff   <= 1'b1;
      end else if (frame_idx_ff == scsf_pkg::FRAMES_PER_BLOCK - 8'h01) begin
        // Block ended with no new start marker: wait for realignment
        frame_idx_ff <= 8'h00;
        aligned_ff   <= 1'b0;
      end else begin
        frame_idx_ff <= frame_idx_ff + 8'h01;
      end
    end
  end

  // Bit position of this frame in the block
  always_comb begin
    nxt_shift = shift_ff;
    if (cs.block_start) begin
      nxt_shift[0] = cs.c_bit;
    end else if (frame_idx_ff < 8'(scsf_pkg::CS_BITS)) begin
      nxt_shift[frame_idx_ff[5:0]] = cs.c_bit;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= 40'h0000000000;
    end else if (cs.sf_valid && cs.sf_first) begin
      shift_ff <= nxt_shift;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs.cs_word <= 40'h0000000000;
      cs.cs_done <= 1'b0;
    end else begin
      cs.cs_done <= 1'b0;
      if (cs.sf_valid && cs.sf_first && !cs.block_start && aligned_ff &&
          frame_idx_ff == scsf_pkg::FRAMES_PER_BLOCK - 8'h01) begin
        cs.cs_word <= shift_ff;
        cs.cs_done <= 1'b1;
      end
    end
  end

endmodule

// *** verilog/scsf_cs_if.sv ***
// Carrier between the flag logic and the channel-status collector
`timescale 1ns/100ps
interface scsf_cs_if;
  logic        sf_valid;
  logic        sf_first;
  logic        c_bit;
  logic        block_start;
  logic [39:0] cs_word;
  logic        cs_done;

  modport top (output sf_valid, output sf_first, output c_bit, output block_start,
               input cs_word, input cs_done);
  modport cap (input sf_valid, input sf_first, input c_bit, input block_start,
               output cs_word, output cs_done);
endinterface

// *** verilog/scsf_pkg.sv ***
// Constants shared by the channel-status capture and status-flag logic
package scsf_pkg;

  // ==========================================================================
  // Register offsets on the host readback port
  localparam logic [6:0] ADDR_SOURCE_CHANNEL   = 7'h2e;
  localparam logic [6:0] ADDR_SAMPLING_CODE_A_ACCURACY    = 7'h2f;
  localparam logic [6:0] ADDR_WORDLEN_ORIGFREQ = 7'h30;
  localparam logic [6:0] ADDR_RX_STATUS        = 7'h31;
  localparam logic [6:0] ADDR_EVENT_FLAGS      = 7'h32;
  localparam logic [6:0] ADDR_GPO_SELECT       = 7'h33;

  // ==========================================================================
  // Channel-status bit positions inside one captured block
  localparam int CS_BITS         = 40;
  localparam int CS_NON_PCM      = 1;
  localparam int CS_SOURCE_LO    = 16;
  localparam int CS_CHANNEL_LO   = 20;
  localparam int CS_SAMPLING_LO  = 24;
  localparam int CS_ACCURACY_LO  = 28;
  localparam int CS_MAX_LEN      = 32;
  localparam int CS_LEN_CODE_LO  = 33;
  localparam int CS_ORIG_RATE_LO = 36;
  localparam logic [7:0] FRAMES_PER_BLOCK = 8'hc0;

  // ==========================================================================
  // Field positions in the status registers
  localparam int STAT_UNLOCK     = 0;
  localparam int STAT_NON_PCM    = 1;
  localparam int STAT_SYNC_CODE  = 2;
  localparam int STAT_NON_AUDIO  = 3;
  localparam int EVT_INVALID     = 0;
  localparam int EVT_TRANSPORT_ERROR_FLAG   = 1;
  localparam int EVT_STATUS_UPD  = 2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RESET_CSTAT    = 8'h00;
  localparam logic [3:0] RESET_GPO_SEL  = 4'h0;
  localparam logic [23:0] RESET_WORD    = 24'h000000;

  // ==========================================================================
  // General output source codes
  localparam logic [3:0] GPO_UNLOCK     = 4'h0;
  localparam logic [3:0] GPO_INVALID    = 4'h1;
  localparam logic [3:0] GPO_TRANSPORT_ERROR_FLAG  = 4'h2;
  localparam logic [3:0] GPO_NON_AUDIO  = 4'h3;
  localparam logic [3:0] GPO_STATUS_UPD = 4'h4;
  localparam logic [3:0] GPO_SYNC_CODE  = 4'h5;

  // ==========================================================================
  // Compressed-data burst preamble words, first and second
  localparam logic [15:0] BURST_SYNC_A  = 16'hf872;
  localparam logic [15:0] BURST_SYNC_B  = 16'h4e1f;

  // ==========================================================================
  // Word-length codes and sizes
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [2:0] LEN_C1   = 3'h1;
  localparam logic [2:0] LEN_C2   = 3'h2;
  localparam logic [2:0] LEN_C4   = 3'h4;
  localparam logic [2:0] LEN_C5   = 3'h5;
  localparam logic [2:0] LEN_C6   = 3'h6;
  localparam int FULL_WORD = 24;

endpackage

// *** verilog/scsf_status_flags.sv ***
// Channel-status registers and receiver status flags, recovered clock domain
//
// What this block does
// - Status bits 19:16 land in low nibble of source/channel register.
// - Status bits 23:20 land in upper nibble as channel number.
// - Status bits 27:24 land in low nibble of frequency register.
// - Status bits 29:28 land in bits 5:4 as clock accuracy.
// - Lock-loss flag follows lock and signal presence; readable, output, mode pin.
// - Invalid flag follows the validity marking of received sub-frames.
// - Transport error set on parity or bi-phase coding violation.
// - Transport error also set on sub-frames out of order.
// - Status bit 1 shown as non-PCM indicator in the receiver status register.
// - Sync-code flag set when a burst preamble appears in data.
// - Only first-channel sub-frames supply channel-status bits.
// - Update flag set on new block, cleared when host reads back.
// - Audio words truncated to captured length, except retransmit path.
// - Non-audio output is OR of sync-code flag and non-PCM bit.
`timescale 1ns/100ps
module scsf_status_flags (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Recovered sub-frame stream from the decoder
  input  wire logic        sf_valid,
  input  wire logic        sf_first,
  input  wire logic        c_bit,
  input  wire logic        v_bit,
  input  wire logic        parity_err,
  input  wire logic        biphase_err,
  input  wire logic        block_start,
  input  wire logic [23:0] audio_word,
  // Pins
  input  wire logic        lock_pin,
  input  wire logic        signal_present_pin,
  input  wire logic        control_mode_pin_in,
  output logic             control_mode_pin_out,
  output logic             control_mode_pin_oe_n,
  output logic             general_output_pin,
  // Host register port
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // Data and indicators
  output logic             non_audio,
  output logic             status_update_flag,
  output logic [23:0]      trunc_word,
  output logic [23:0]      retx_word
);

  // ==========================================================================
  // Collector
  scsf_cs_if cs_bus ();

  // Same-clock stream passes straight into the collector
  assign cs_bus.sf_valid    = sf_valid;
  assign cs_bus.sf_first    = sf_first;
  assign cs_bus.c_bit       = c_bit;
  assign cs_bus.block_start = block_start;

  scsf_cs_capture u_capture (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cs      (cs_bus.cap)
  );

  // ==========================================================================
  // Pin synchronisers
  logic lock_s1_ff;
  logic lock_s2_ff;
  logic present_s1_ff;
  logic present_s2_ff;
  logic mode_s1_ff;
  logic mode_s2_ff;

  // Two stages before any logic reads a pin
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_s1_ff    <= 1'b0;
      lock_s2_ff    <= 1'b0;
      present_s1_ff <= 1'b0;
      present_s2_ff <= 1'b0;
      mode_s1_ff    <= 1'b1;
      mode_s2_ff    <= 1'b1;
    end else begin
      lock_s1_ff    <= lock_pin;
      lock_s2_ff    <= lock_s1_ff;
      present_s1_ff <= signal_present_pin;
      present_s2_ff <= present_s1_ff;
      mode_s1_ff    <= control_mode_pin_in;
      mode_s2_ff    <= mode_s1_ff;
    end
  end

  // ==========================================================================
  // Mode strap
  logic [1:0] strap_cnt_ff;
  logic       hw_mode_ff;

  // Final at third edge, past the synchroniser's reset value; low = hardware
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_ff <= 2'h0;
      hw_mode_ff   <= 1'b0;
    end else if (strap_cnt_ff != 2'h3) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      hw_mode_ff   <= ~mode_s2_ff;
    end
  end

  // ==========================================================================
  // Captured channel-status registers
  logic [7:0] source_channel_ff;
  logic [7:0] sampling_code_a_accuracy_ff;
  logic [7:0] wordlen_origfreq_ff;
  logic       non_pcm_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      source_channel_ff   <= scsf_pkg::RESET_CSTAT;
      sampling_code_a_accuracy_ff    <= scsf_pkg::RESET_CSTAT;
      wordlen_origfreq_ff <= scsf_pkg::RESET_CSTAT;
      non_pcm_ff          <= 1'b0;
    end else if (cs_bus.cs_done) begin
      source_channel_ff[3:0] <= cs_bus.cs_word[scsf_pkg::CS_SOURCE_LO +: 4];
      source_channel_ff[7:4] <= cs_bus.cs_word[scsf_pkg::CS_CHANNEL_LO +: 4];
      sampling_code_a_accuracy_ff[3:0]  <= cs_bus.cs_word[scsf_pkg::CS_SAMPLING_LO +: 4];
      sampling_code_a_accuracy_ff[5:4]  <= cs_bus.cs_word[scsf_pkg::CS_ACCURACY_LO +: 2];
      sampling_code_a_accuracy_ff[7:6]  <= 2'b00;
      wordlen_origfreq_ff[0]   <= cs_bus.cs_word[scsf_pkg::CS_MAX_LEN];
      wordlen_origfreq_ff[3:1] <= cs_bus.cs_word[scsf_pkg::CS_LEN_CODE_LO +: 3];
      wordlen_origfreq_ff[7:4] <= cs_bus.cs_word[scsf_pkg::CS_ORIG_RATE_LO +: 4];
      non_pcm_ff <= cs_bus.cs_word[scsf_pkg::CS_NON_PCM];
    end
  end

  // ==========================================================================
  // Word length and truncation
  logic [4:0]  word_len;
  logic [23:0] nxt_len_mask;
  logic [23:0] len_mask_ff;

  // Sample length from flag and code; unknown codes take 16 bits, or 20 with the flag
  always_comb begin
    case (wordlen_origfreq_ff[3:1])
      scsf_pkg::LEN_C1: word_len = 5'd16;
      scsf_pkg::LEN_C2: word_len = 5'd18;
      scsf_pkg::LEN_C4: word_len = 5'd19;
      scsf_pkg::LEN_C5: word_len = 5'd20;
      scsf_pkg::LEN_C6: word_len = 5'd17;
      default:          word_len = 5'd16;
    endcase
    if (wordlen_origfreq_ff[0]) begin
      word_len = word_len + 5'd4;
    end
    if (wordlen_origfreq_ff[3:1] == scsf_pkg::LEN_NONE) begin
      word_len = wordlen_origfreq_ff[0] ? 5'd24 : 5'd20;
    end
    nxt_len_mask = ~(24'hffffff >> word_len);
  end

  // Mask registered so the decode stays off the data path
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      len_mask_ff <= 24'hffffff;
    end else begin
      len_mask_ff <= nxt_len_mask;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trunc_word <= scsf_pkg::RESET_WORD;
      retx_word  <= scsf_pkg::RESET_WORD;
    end else if (sf_valid) begin
      trunc_word <= audio_word & len_mask_ff;
      retx_word  <= audio_word;
    end
  end

  // ==========================================================================
  // Lock loss
  logic unlock_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_ff <= 1'b1;
    end else begin
      unlock_ff <= ~(lock_s2_ff & present_s2_ff);
    end
  end

  // ==========================================================================
  // Sub-frame checks
  logic invalid_ff;
  logic transport_error_flag_ff;
  logic prev_first_ff;
  logic seen_ff;
  logic order_err;

  // Two sub-frames of the same channel in a row means a lost preamble
  assign order_err = seen_ff && (sf_first == prev_first_ff);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_first_ff <= 1'b0;
      seen_ff       <= 1'b0;
    end else if (unlock_ff) begin
      seen_ff <= 1'b0;
    end else if (sf_valid) begin
      prev_first_ff <= sf_first;
      seen_ff       <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      invalid_ff <= 1'b0;
    end else if (sf_valid) begin
      invalid_ff <= v_bit;
    end
  end

  // coding errors; a clean first sub-frame clears it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      transport_error_flag_ff <= 1'b0;
    end else if (sf_valid) begin
      if (parity_err || biphase_err || order_err) begin
        transport_error_flag_ff <= 1'b1;
      end else if (sf_first) begin
        transport_error_flag_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Burst sync code
  logic pa_seen_ff;
  logic sync_code_ff;

  // preamble pair in one frame; held until lock is lost
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pa_seen_ff   <= 1'b0;
      sync_code_ff <= 1'b0;
    end else if (unlock_ff) begin
      pa_seen_ff   <= 1'b0;
      sync_code_ff <= 1'b0;
    end else if (sf_valid) begin
      pa_seen_ff <= sf_first && (audio_word[23:8] == scsf_pkg::BURST_SYNC_A);
      if (!sf_first && pa_seen_ff && audio_word[23:8] == scsf_pkg::BURST_SYNC_B) begin
        sync_code_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      non_audio <= 1'b0;
    end else begin
      non_audio <= sync_code_ff | non_pcm_ff;
    end
  end

  // ==========================================================================
  // Update flag
  logic cs_read;

  assign cs_read = reg_rd && (reg_addr == scsf_pkg::ADDR_SOURCE_CHANNEL ||
                              reg_addr == scsf_pkg::ADDR_SAMPLING_CODE_A_ACCURACY ||
                              reg_addr == scsf_pkg::ADDR_WORDLEN_ORIGFREQ);

  // new block wins over a readback in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_update_flag <= 1'b0;
    end else if (cs_bus.cs_done) begin
      status_update_flag <= 1'b1;
    end else if (cs_read) begin
      status_update_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Host register port
  logic [3:0] gpo_sel_ff;
  logic [7:0] rx_status;
  logic [7:0] event_flags;

  // Only the output select takes writes
  // captured registers ignore writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gpo_sel_ff <= scsf_pkg::RESET_GPO_SEL;
    end else if (reg_wr && reg_addr == scsf_pkg::ADDR_GPO_SELECT) begin
      gpo_sel_ff <= reg_wdata[3:0];
    end
  end

  // Live status fields
  always_comb begin
    rx_status = 8'h00;
    rx_status[scsf_pkg::STAT_UNLOCK]    = unlock_ff;
    rx_status[scsf_pkg::STAT_NON_PCM]   = non_pcm_ff;
    rx_status[scsf_pkg::STAT_SYNC_CODE] = sync_code_ff;
    rx_status[scsf_pkg::STAT_NON_AUDIO] = non_audio;
    event_flags = 8'h00;
    event_flags[scsf_pkg::EVT_INVALID]    = invalid_ff;
    event_flags[scsf_pkg::EVT_TRANSPORT_ERROR_FLAG]  = transport_error_flag_ff;
    event_flags[scsf_pkg::EVT_STATUS_UPD] = status_update_flag;
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == scsf_pkg::ADDR_SOURCE_CHANNEL) begin
        reg_rdata <= source_channel_ff;
      end else if (reg_addr == scsf_pkg::ADDR_SAMPLING_CODE_A_ACCURACY) begin
        reg_rdata <= sampling_code_a_accuracy_ff;
      end else if (reg_addr == scsf_pkg::ADDR_WORDLEN_ORIGFREQ) begin
        reg_rdata <= wordlen_origfreq_ff;
      end else if (reg_addr == scsf_pkg::ADDR_RX_STATUS) begin
        reg_rdata <= rx_status;
      end else if (reg_addr == scsf_pkg::ADDR_EVENT_FLAGS) begin
        reg_rdata <= event_flags;
      end else if (reg_addr == scsf_pkg::ADDR_GPO_SELECT) begin
        reg_rdata <= {4'h0, gpo_sel_ff};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Output pins
  // lock loss on output pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      general_output_pin    <= 1'b1;
      control_mode_pin_out  <= 1'b1;
      control_mode_pin_oe_n <= 1'b1;
    end else begin
      case (gpo_sel_ff)
        scsf_pkg::GPO_INVALID:    general_output_pin <= invalid_ff;
        scsf_pkg::GPO_TRANSPORT_ERROR_FLAG:  general_output_pin <= transport_error_flag_ff;
        scsf_pkg::GPO_NON_AUDIO:  general_output_pin <= sync_code_ff | non_pcm_ff;
        scsf_pkg::GPO_STATUS_UPD: general_output_pin <= status_update_flag;
        scsf_pkg::GPO_SYNC_CODE:  general_output_pin <= sync_code_ff;
        default:                  general_output_pin <= unlock_ff;
      endcase
      // Mode pin driven only in hardware mode
      control_mode_pin_out  <= unlock_ff;
      control_mode_pin_oe_n <= ~((strap_cnt_ff == 2'h3) & hw_mode_ff);
    end
  end

endmodule
